/* File: tb/far_side_model.sv */
// processor side model: nmi handler that clears sources and restores diskette power
`timescale 1ns/10ps
module far_side_model (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic power_down_i,
	input wire logic [4:0] nmi_src_i,
	output logic [4:0] nmi_clr_o,
	output logic fdc_power_o
);
	logic [3:0] dly;
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dly <= 4'h0;
			nmi_clr_o <= 5'h00;
			fdc_power_o <= 1'b1;
		end else begin
			nmi_clr_o <= 5'h00;
			if (power_down_i)
				fdc_power_o <= 1'b0;
			if (nmi_src_i != 5'h00 && nmi_clr_o == 5'h00) begin
				dly <= dly + 4'h1;
				// handler latency, then power back before retry
				if (dly == 4'h5) begin
					dly <= 4'h0;
					nmi_clr_o <= nmi_src_i;
					if (nmi_src_i[1])
						fdc_power_o <= 1'b1;
				end
			end
		end
	end
endmodule

/* File: tb/tb_top.sv */
// testbench for nmi latching and request level routing
`timescale 1ns/10ps
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic pd = 1'b0;
	logic ce = 1'b1;
	logic [7:0] wdata = 8'h00;
	logic [4:0] lvs = 5'h00;
	logic [2:0] ev = 3'h0;
	logic [7:0] lv = 8'h00;
	logic [7:0] rdata, irq, isv;
	logic [4:0] nsrc, clr;
	logic [2:0] ackl;
	logic nmi, pwr;
	int n_errors = 0;
	int n_compared = 0;
	int c;
	logic [15:0] fp [3];
	always #5 clk_sys_i = ~clk_sys_i;
	nmi_irq_routing #(.TICK_CYC(3000)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
		.io_addr_i(addr), .io_rd_i(rd), .io_wr_i(wr), .io_wdata_i(wdata), .io_rdata_o(rdata),
		.chan_check_i(lvs[0]), .fdc_power_i(pwr), .suspend_i(lvs[1]), .rtc_periodic_i(lvs[2]),
		.rtc_update_i(lvs[3]), .rtc_alarm_i(lvs[4]), .key_detect_i(ev[0]), .nmi_clr_i(clr),
		.fdc_irq_i(lv[6]), .com1_irq_i(lv[4]), .com2_irq_i(lv[3]), .gen2_irq_i(lv[2]),
		.gen5_irq_i(lv[5]), .prn_irq_i(lv[7]), .inta_i(ev[1]), .eoi_i(ev[2]), .nmi_o(nmi),
		.nmi_src_o(nsrc), .irq_o(irq), .in_service_o(isv), .ack_level_o(ackl));
	far_side_model partner (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .power_down_i(pd),
		.nmi_src_i(nsrc), .nmi_clr_o(clr), .fdc_power_o(pwr));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		addr = a;
		wdata = d;
		wr = w;
		rd = ~w;
		@(negedge clk_sys_i);
		wr = 1'b0;
		rd = 1'b0;
	endtask
	task automatic pulse(input int i);
		@(negedge clk_sys_i);
		ev[i] = 1'b1;
		@(negedge clk_sys_i);
		ev[i] = 1'b0;
		@(negedge clk_sys_i);
	endtask
	task automatic nmi_wait(input int b, input logic e);
		for (int i = 0; i < 4 && nsrc[b] !== 1'b1; i++) @(negedge clk_sys_i);
		chk({7'h00, nsrc[b]}, {7'h00, e});
		chk({7'h00, nmi}, {7'h00, e});
		for (int i = 0; i < 20 && nsrc !== 5'h00; i++) @(negedge clk_sys_i);
	endtask
	task automatic power_off();
		@(negedge clk_sys_i);
		pd = 1'b1;
		@(negedge clk_sys_i);
		pd = 1'b0;
		@(negedge clk_sys_i);
	endtask
	task automatic results();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		results();
	end
	initial begin
		fp = '{nmi_irq_pkg::FDC_DOR_PORT, nmi_irq_pkg::FDC_MSR_PORT, nmi_irq_pkg::FDC_DATA_PORT};
		repeat (8) @(negedge clk_sys_i);
		rst_i = 1'b0;
		for (int i = 0; i < 5; i++) begin
			@(negedge clk_sys_i);
			lvs[i] = 1'b1;
			nmi_wait(i == 0 ? 0 : i == 1 ? 2 : 3, 1'b1);
			lvs[i] = 1'b0;
		end
		power_off();
		io(1'b1, nmi_irq_pkg::FDC_DOR_PORT, 8'h01);
		nmi_wait(1, 1'b0);
		for (int i = 0; i < 3; i++) begin
			power_off();
			io(i == 0, fp[i], 8'h11);
			nmi_wait(1, 1'b1);
			io(i == 0, fp[i], 8'h11);
			nmi_wait(1, 1'b0);
		end
		for (int l = 2; l < 8; l++) begin
			@(negedge clk_sys_i);
			lv[l] = 1'b1;
			repeat (2) @(negedge clk_sys_i);
			chk(irq & 8'hfc, 8'h01 << l);
			lv[l] = 1'b0;
			repeat (2) @(negedge clk_sys_i);
		end
		pulse(1);
		chk({5'h00, ackl}, 8'h07);
		chk(isv, 8'h00);
		pulse(0);
		nmi_wait(4, 1'b1);
		io(1'b1, nmi_irq_pkg::SCAN_PORT, 8'h5a);
		@(negedge clk_sys_i);
		chk(irq & 8'h02, 8'h02);
		pulse(1);
		chk({5'h00, ackl}, 8'h01);
		chk(isv, 8'h02);
		pulse(0);
		io(1'b0, nmi_irq_pkg::SCAN_PORT, 8'h00);
		chk(rdata, 8'h5a);
		// unmapped port must read zero, not the last value
		io(1'b0, 16'h0070, 8'h00);
		chk(rdata, 8'h00);
		nmi_wait(4, 1'b0);
		io(1'b1, nmi_irq_pkg::KBCTL_PORT, 8'h80);
		@(negedge clk_sys_i);
		chk(irq & 8'h02, 8'h00);
		io(1'b0, nmi_irq_pkg::KBCTL_PORT, 8'h00);
		chk(rdata, 8'h80);
		nmi_wait(4, 1'b0);
		pulse(2);
		nmi_wait(4, 1'b1);
		chk(isv, 8'h00);
		// scan write while clock enable is low must be dropped
		ce = 1'b0;
		io(1'b1, nmi_irq_pkg::SCAN_PORT, 8'h33);
		ce = 1'b1;
		chk(irq & 8'h02, 8'h00);
		io(1'b0, nmi_irq_pkg::SCAN_PORT, 8'h00);
		chk(rdata, 8'h5a);
		for (c = 0; c < 3100 && irq[0] !== 1'b1; c++) @(negedge clk_sys_i);
		chk({7'h00, irq[0]}, 8'h01);
		pulse(1);
		chk({5'h00, ackl}, 8'h00);
		pulse(2);
		for (c = 0; c < 3100 && irq[0] !== 1'b1; c++) @(negedge clk_sys_i);
		chk({7'h00, c > 2900 && c < 3000}, 8'h01);
		results();
	end
endmodule

/* File: verilog/nmi_irq_pkg.sv */
// constants for nmi and interrupt request routing
package nmi_irq_pkg;
	localparam logic [15:0] SCAN_PORT = 16'h0060;
	localparam logic [15:0] KBCTL_PORT = 16'h0061;
	localparam logic [15:0] FDC_DOR_PORT = 16'h03f2;
	localparam logic [15:0] FDC_MSR_PORT = 16'h03f4;
	localparam logic [15:0] FDC_DATA_PORT = 16'h03f5;
	localparam int KBCLR_BIT = 7;
	localparam logic [7:0] DRVSEL_MASK = 8'h03;
	localparam logic [7:0] SCAN_RST = 8'h00;
	localparam logic [7:0] KBCTL_RST = 8'h00;
	localparam logic [7:0] DOR_RST = 8'h00;
	// nmi source positions
	localparam int NMI_CHK = 0;
	localparam int NMI_FDC = 1;
	localparam int NMI_SUSP = 2;
	localparam int NMI_RTC = 3;
	localparam int NMI_KEY = 4;
	localparam int NMI_NUM = 5;
	// request levels
	localparam int LVL_TIMER = 0;
	localparam int LVL_KEY = 1;
	localparam int LVL_GEN2 = 2;
	localparam int LVL_COM2 = 3;
	localparam int LVL_COM1 = 4;
	localparam int LVL_GEN5 = 5;
	localparam int LVL_FDC = 6;
	localparam int LVL_PRN = 7;
	localparam logic [2:0] SPURIOUS_LVL = 3'h7;
	// timer 0 tick period
	localparam int CLK_MHZ = 100;
	localparam int TICK_MS = 55;
	localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
	typedef enum logic [1:0] {
		KB_IDLE = 2'b00,
		KB_BUSY = 2'b01,
		KB_HOLD = 2'b10
	} kb_state_e;
endpackage

/* File: verilog/nmi_irq_routing.sv */
// nmi source latching, keyboard hand-off ports and request level routing
`timescale 1ns/10ps
// Operation
// - channel check line raises nmi
// - diskette port access while unpowered raises nmi
// - drive select change alone raises nothing
// - power-off suspend raises nmi
// - clock periodic, update, alarm events raise nmi
// - keystroke raises nmi; keys during hand-off merge into one pending nmi
// - next key nmi needs read and toggle
// - next key nmi waits for level-1 end
// - scan port write asserts level-1 request
// - level-1 cleared by clear bit toggle
// - timer 0 requests level 0 every 55 ms
// - diskette controller drives level 6
// - level 3 secondary, level 4 primary adapter
// - level 7 printer and spurious requests
// - in-service set only for valid acknowledge
// - levels 2 and 5 for general devices
module nmi_irq_routing #(
	parameter int unsigned TICK_CYC = nmi_irq_pkg::TICK_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [15:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	input wire logic chan_check_i,
	input wire logic fdc_power_i,
	input wire logic suspend_i,
	input wire logic rtc_periodic_i,
	input wire logic rtc_update_i,
	input wire logic rtc_alarm_i,
	input wire logic key_detect_i,
	input wire logic [4:0] nmi_clr_i,
	input wire logic fdc_irq_i,
	input wire logic com1_irq_i,
	input wire logic com2_irq_i,
	input wire logic gen2_irq_i,
	input wire logic gen5_irq_i,
	input wire logic prn_irq_i,
	input wire logic inta_i,
	input wire logic eoi_i,
	output logic nmi_o,
	output logic [4:0] nmi_src_o,
	output logic [7:0] irq_o,
	output logic [7:0] in_service_o,
	output logic [2:0] ack_level_o
);
	logic [7:0] scan_code;
	logic [7:0] kb_ctl;
	logic [7:0] dor_shadow;
	logic [4:0] next_src;
	logic [2:0] ev_prev;
	logic [2:0] ev_now;
	logic [31:0] tick_cnt;
	logic tick_req;
	logic [7:0] raw_req;
	logic [7:0] req_prev;
	logic [7:0] req_ok;
	logic kb_state_key_nmi;
	logic key_pend;
	logic read_seen;
	logic toggle_seen;
	logic fdc_hit;
	logic wr_scan;
	logic rd_scan;
	logic kb_toggle;
	logic l1_eoi;
	logic [3:0] ack_pick;
	logic [3:0] isv_pick;
	nmi_irq_pkg::kb_state_e kb_state;

	// highest priority level (0 first) and whether any bit is set
	function automatic logic [3:0] prio(input logic [7:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	// winning valid request and top in-service level
	assign ack_pick = prio(req_ok);
	assign isv_pick = prio(in_service_o);

	assign wr_scan = io_wr_i && io_addr_i == nmi_irq_pkg::SCAN_PORT;
	assign rd_scan = io_rd_i && io_addr_i == nmi_irq_pkg::SCAN_PORT;
	assign kb_toggle = io_wr_i && io_addr_i == nmi_irq_pkg::KBCTL_PORT &&
		io_wdata_i[nmi_irq_pkg::KBCLR_BIT] != kb_ctl[nmi_irq_pkg::KBCLR_BIT];
	assign l1_eoi = eoi_i && isv_pick == {1'b1, 3'(nmi_irq_pkg::LVL_KEY)};

	// diskette access while unpowered; a drive select change alone is exempt
	always_comb begin
		fdc_hit = 1'b0;
		if (!fdc_power_i && (io_rd_i || io_wr_i)) begin
			if (io_addr_i == nmi_irq_pkg::FDC_MSR_PORT || io_addr_i == nmi_irq_pkg::FDC_DATA_PORT) begin
				fdc_hit = 1'b1;
			end else if (io_addr_i == nmi_irq_pkg::FDC_DOR_PORT) begin
				fdc_hit = !(io_wr_i && ((io_wdata_i ^ dor_shadow) & ~nmi_irq_pkg::DRVSEL_MASK) == 8'h00
					&& io_wdata_i != dor_shadow);
			end
		end
	end

	assign ev_now = {suspend_i, chan_check_i, rtc_periodic_i | rtc_update_i | rtc_alarm_i};

	// per-source sticky latches, set wins over clear
	always_comb begin
		next_src = nmi_src_o & ~nmi_clr_i;
		if (ev_now[1] && !ev_prev[1]) next_src[nmi_irq_pkg::NMI_CHK] = 1'b1;
		if (fdc_hit) next_src[nmi_irq_pkg::NMI_FDC] = 1'b1;
		if (ev_now[2] && !ev_prev[2]) next_src[nmi_irq_pkg::NMI_SUSP] = 1'b1;
		if (ev_now[0] && !ev_prev[0]) next_src[nmi_irq_pkg::NMI_RTC] = 1'b1;
		if (kb_state_key_nmi) next_src[nmi_irq_pkg::NMI_KEY] = 1'b1;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			nmi_src_o <= 5'h00;
			nmi_o <= 1'b0;
			ev_prev <= 3'h0;
		end else if (ce_i) begin
			nmi_src_o <= next_src;
			nmi_o <= |next_src;
			ev_prev <= ev_now;
		end
	end

	// keyboard hand-off sequencing
	always_comb begin
		kb_state_key_nmi = 1'b0;
		case (kb_state)
			nmi_irq_pkg::KB_IDLE: kb_state_key_nmi = key_detect_i || key_pend;
			nmi_irq_pkg::KB_HOLD: kb_state_key_nmi = l1_eoi && (key_detect_i || key_pend);
			default: kb_state_key_nmi = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			kb_state <= nmi_irq_pkg::KB_IDLE;
			key_pend <= 1'b0;
			read_seen <= 1'b0;
			toggle_seen <= 1'b0;
		end else if (ce_i) begin
			if (kb_state_key_nmi) key_pend <= 1'b0;
			else if (key_detect_i) key_pend <= 1'b1;
			case (kb_state)
				nmi_irq_pkg::KB_IDLE: begin
					if (kb_state_key_nmi) kb_state <= nmi_irq_pkg::KB_BUSY;
					read_seen <= 1'b0;
					toggle_seen <= 1'b0;
				end
				nmi_irq_pkg::KB_BUSY: begin
					if (rd_scan) read_seen <= 1'b1;
					if (kb_toggle) toggle_seen <= 1'b1;
					if ((read_seen || rd_scan) && (toggle_seen || kb_toggle)) begin
						kb_state <= nmi_irq_pkg::KB_HOLD;
					end
				end
				nmi_irq_pkg::KB_HOLD: begin
					read_seen <= 1'b0;
					toggle_seen <= 1'b0;
					if (l1_eoi) begin
						kb_state <= kb_state_key_nmi ? nmi_irq_pkg::KB_BUSY
							: nmi_irq_pkg::KB_IDLE;
					end
				end
				default: kb_state <= nmi_irq_pkg::KB_IDLE;
			endcase
		end
	end

	// port registers and read data
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			scan_code <= nmi_irq_pkg::SCAN_RST;
			kb_ctl <= nmi_irq_pkg::KBCTL_RST;
			dor_shadow <= nmi_irq_pkg::DOR_RST;
			io_rdata_o <= 8'h00;
		end else if (ce_i) begin
			if (wr_scan) scan_code <= io_wdata_i;
			if (io_wr_i && io_addr_i == nmi_irq_pkg::KBCTL_PORT) kb_ctl <= io_wdata_i;
			if (io_wr_i && io_addr_i == nmi_irq_pkg::FDC_DOR_PORT) dor_shadow <= io_wdata_i;
			if (io_rd_i) begin
				case (io_addr_i)
					nmi_irq_pkg::SCAN_PORT: io_rdata_o <= scan_code;
					nmi_irq_pkg::KBCTL_PORT: io_rdata_o <= kb_ctl;
					default: io_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// timer 0 tick source
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt <= 32'h0;
			tick_req <= 1'b0;
		end else if (ce_i) begin
			if (tick_cnt == 32'(TICK_CYC - 1)) begin
				tick_cnt <= 32'h0;
				tick_req <= 1'b1;
			end else begin
				tick_cnt <= tick_cnt + 32'h1;
				if (inta_i && ack_pick == {1'b1, 3'(nmi_irq_pkg::LVL_TIMER)}) tick_req <= 1'b0;
			end
		end
	end

	always_comb begin
		raw_req = 8'h00;
		raw_req[nmi_irq_pkg::LVL_TIMER] = tick_req;
		raw_req[nmi_irq_pkg::LVL_KEY] = irq_o[nmi_irq_pkg::LVL_KEY];
		raw_req[nmi_irq_pkg::LVL_GEN2] = gen2_irq_i;
		raw_req[nmi_irq_pkg::LVL_COM2] = com2_irq_i;
		raw_req[nmi_irq_pkg::LVL_COM1] = com1_irq_i;
		raw_req[nmi_irq_pkg::LVL_GEN5] = gen5_irq_i;
		raw_req[nmi_irq_pkg::LVL_FDC] = fdc_irq_i;
		raw_req[nmi_irq_pkg::LVL_PRN] = prn_irq_i;
	end

	// a request counts as valid once held two cycles
	assign req_ok = irq_o & req_prev;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 8'h00;
			req_prev <= 8'h00;
			in_service_o <= 8'h00;
			ack_level_o <= 3'h0;
		end else if (ce_i) begin
			irq_o <= raw_req;
			req_prev <= irq_o;
			if (wr_scan) irq_o[nmi_irq_pkg::LVL_KEY] <= 1'b1;
			else if (kb_toggle) irq_o[nmi_irq_pkg::LVL_KEY] <= 1'b0;
			if (inta_i) begin
				if (ack_pick[3]) begin
					ack_level_o <= ack_pick[2:0];
					in_service_o[ack_pick[2:0]] <= 1'b1;
				end else begin
					ack_level_o <= nmi_irq_pkg::SPURIOUS_LVL;
				end
			end else if (eoi_i && isv_pick[3]) begin
				in_service_o[isv_pick[2:0]] <= 1'b0;
			end
		end
	end

	a_chk_nmi: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && chan_check_i && !ev_prev[1] |=> nmi_src_o[nmi_irq_pkg::NMI_CHK] && nmi_o)
		else $error("channel check did not raise nmi");
	a_fdc_off_nmi: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && !fdc_power_i && io_rd_i && io_addr_i == nmi_irq_pkg::FDC_MSR_PORT
		|=> nmi_src_o[nmi_irq_pkg::NMI_FDC])
		else $error("unpowered diskette access missed");
	a_fdc_on_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && fdc_power_i && !nmi_src_o[nmi_irq_pkg::NMI_FDC] |=> !nmi_src_o[nmi_irq_pkg::NMI_FDC])
		else $error("diskette nmi while powered");
	a_key_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		kb_state == nmi_irq_pkg::KB_BUSY |-> !kb_state_key_nmi)
		else $error("key nmi before read and toggle");
	a_key_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		kb_state == nmi_irq_pkg::KB_HOLD && !l1_eoi |-> !kb_state_key_nmi)
		else $error("key nmi before level-1 end");
	a_scan_irq1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && wr_scan |=> irq_o[nmi_irq_pkg::LVL_KEY] && scan_code == $past(io_wdata_i))
		else $error("scan write did not request level 1");
	a_irq1_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && kb_toggle && !wr_scan |=> !irq_o[nmi_irq_pkg::LVL_KEY])
		else $error("clear bit toggle left level 1 set");
	a_spurious: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && inta_i && req_ok == 8'h00 |=> ack_level_o == nmi_irq_pkg::SPURIOUS_LVL
		&& in_service_o == $past(in_service_o))
		else $error("spurious ack altered in-service");
	a_nmi_combine: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		nmi_o == (nmi_src_o != 5'h00))
		else $error("nmi not the union of sources");
	a_valid_ack: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && inta_i && ack_pick[3] |=> ack_level_o == $past(ack_pick[2:0])
		&& in_service_o[ack_level_o])
		else $error("valid ack left in-service clear");
	a_disk_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i |=> irq_o[nmi_irq_pkg::LVL_FDC] == $past(fdc_irq_i)
		&& irq_o[nmi_irq_pkg::LVL_PRN] == $past(prn_irq_i))
		else $error("device request not on its level");
	a_serial_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i |=> irq_o[nmi_irq_pkg::LVL_COM2] == $past(com2_irq_i)
		&& irq_o[nmi_irq_pkg::LVL_COM1] == $past(com1_irq_i))
		else $error("serial request not on its level");
	a_tick_wrap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && tick_cnt == 32'(TICK_CYC - 1)
		|=> tick_req && tick_cnt == 32'h0)
		else $error("timer tick not raised at wrap");
	c_key_cycle: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		kb_state == nmi_irq_pkg::KB_HOLD ##[1:50] kb_state == nmi_irq_pkg::KB_BUSY);
	c_spurious: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		inta_i && req_ok == 8'h00);
	c_two_nmi: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		nmi_src_o[nmi_irq_pkg::NMI_RTC] && nmi_src_o[nmi_irq_pkg::NMI_SUSP]);
	c_fdc_nmi: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && fdc_hit);
	c_timer_ack: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		inta_i && ack_pick == {1'b1, 3'(nmi_irq_pkg::LVL_TIMER)});
endmodule
